/* core/dtf_defs.svh */
`ifndef DTF_DEFS_SVH
`define DTF_DEFS_SVH
// ---------------------------------------------------------------
// register indices on the plain register port
// ---------------------------------------------------------------
`define DTF_REG_CTRL   2'h0
`define DTF_REG_FIFOH  2'h1
`define DTF_REG_FIFOL  2'h2
`define DTF_REG_COUNT  2'h3
// ---------------------------------------------------------------
// control register fields and sizes
// ---------------------------------------------------------------
`define DTF_ARM_BIT    0
`define DTF_END_BIT    1
`define DTF_EVT_BIT    2
`define DTF_CTRL_RST   3'h0
`define DTF_BLANK_CYC  2'h2
`define DTF_FIFO_DEPTH 8
`define DTF_ADDR_W     16
`define DTF_DATA_W     8
`define DTF_ZERO_BYTE  8'h00
`define DTF_ZERO_WORD  16'h0000
`endif

/* core/dtf_pkg.sv */
package dtf_pkg;
  // ---------------------------------------------------------------
  // change-of-flow classes reported with each executed opcode
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    COF_SEQ, COF_COND_TAKEN, COF_BRANCH_ALWAYS_INSN,
    COF_BRANCH_NEVER_INSN, COF_JUMP_INSN_IND,
    COF_JUMP_SUBROUTINE_INSN_IND, COF_INTERRUPT,
    COF_RETURN_FROM_INTERRUPT_INSN, COF_RETURN_SUB, COF_DIRECT
  } dtf_cof_t;
  // trace sequencer states
  typedef enum logic [2:0] {
    ST_IDLE, ST_WAIT, ST_BLANK, ST_RUN, ST_DONE
  } dtf_state_t;
  // cpu side events, all on the bus clock
  typedef struct packed {
    logic        fetch_valid;
    logic        fetch_tag;
    logic [15:0] fetch_addr;
    logic        flush;
    logic        exec_valid;
    logic [15:0] exec_addr;
    dtf_cof_t    cof_kind;
    logic [15:0] dest_addr;
  } dtf_cpu_t;
  // software control bits
  typedef struct packed {
    logic evt_only;
    logic end_trace;
    logic arm;
  } dtf_ctrl_t;
endpackage : dtf_pkg

/* core/dtf_trace.sv */
// Added by the designer: the plain strobed port and the register offsets.
`timescale 1ns/100ps
`include "dtf_defs.svh"
// ---------------------------------------------------------------
// capture fifo
// ---------------------------------------------------------------
module dtf_fifo #(
  parameter int W = `DTF_ADDR_W,
  parameter int D = `DTF_FIFO_DEPTH
) (
  input  wire logic                   mclk,
  input  wire logic                   nrst,
  input  wire logic                   in_valid,
  output logic                        in_ready,
  input  wire logic [W-1:0]           in_data,
  output logic                        out_valid,
  input  wire logic                   out_ready,
  output logic [W-1:0]                out_data,
  output logic [$clog2(D+1)-1:0]      level
);
  localparam int PW = $clog2(D);
  localparam int LW = $clog2(D+1);
  logic [W-1:0]  mem_q [D];
  logic [PW-1:0] wp_q, wp_d, rp_q, rp_d;
  logic [LW-1:0] lvl_q, lvl_d;
  logic          wr, rd;

  // flags from the occupancy count; a pop frees room for a push
  assign in_ready  = (lvl_q != LW'(D)) | out_ready;
  assign out_valid = (lvl_q != '0);
  assign out_data  = mem_q[rp_q];
  assign level     = lvl_q;
  assign wr        = in_valid & in_ready;
  assign rd        = out_valid & out_ready;

  // pointer and count next values
  always_comb begin
    wp_d  = wp_q;
    rp_d  = rp_q;
    lvl_d = lvl_q;
    if (wr)
      wp_d = (wp_q == PW'(D-1)) ? '0 : wp_q + 1'b1;
    if (rd)
      rp_d = (rp_q == PW'(D-1)) ? '0 : rp_q + 1'b1;
    if (wr && !rd)
      lvl_d = lvl_q + 1'b1;
    else if (rd && !wr)
      lvl_d = lvl_q - 1'b1;
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      wp_q  <= '0;
      rp_q  <= '0;
      lvl_q <= '0;
    end else begin
      wp_q  <= wp_d;
      rp_q  <= rp_d;
      lvl_q <= lvl_d;
    end
  end

  // storage, written only on an accepted push
  always_ff @(posedge mclk) begin
    if (wr)
      mem_q[wp_q] <= in_data;
  end
endmodule : dtf_fifo

// ---------------------------------------------------------------
// trace capture top
// ---------------------------------------------------------------
// Functional notes
// (RULE1) When fewer than eight entries are valid the host dummy-reads (8 - count) - 1 times before the first useful entry.
// (RULE2) For address trace the host reads the high byte before the low byte to get one coherent word.
// (RULE3) Reading the low byte advances the fifo so the next entry is presented.
// (RULE4) Event-only modes store 8-bit values with an unused high byte read through the low byte alone.
// (RULE5) A change-of-flow on the starting trigger or in the two cycles after it is not captured.
// (RULE6) In end-trace a change-of-flow that is the trigger is stored as the last entry of the run.
// (RULE7) While not armed each low-byte read pushes the last fetched opcode address.
// (RULE8) The fifo holds eight entries so eight low-byte reads first fill it when profiling.
// (RULE9) A profiling host reads high then low periodically and drops the first eight samples.
// (RULE10) Only instructions that break sequential flow make an entry.
// (RULE11) A taken conditional branch stores the address of its own opcode.
// (RULE12) Branch-always and branch-never make no entry.
// (RULE13) Indirect jump and indirect subroutine jump store the run-time destination.
// (RULE14) Interrupt entry and both returns store the destination address.
// (RULE15) A tag marks an opcode at fetch and acts only if it executes; a flush cancels it.
// (RULE16) A valid-entry count rises per capture, saturates at depth and is readable.
module dtf_trace #(
  parameter int DEPTH = `DTF_FIFO_DEPTH
) (
  input  wire logic                   mclk,
  input  wire logic                   nrst,
  input  wire dtf_pkg::dtf_cpu_t      cpu,
  input  wire logic [7:0]             evt_data,
  input  wire logic [1:0]             reg_addr,
  input  wire logic [7:0]             reg_wdata,
  input  wire logic                   reg_wr,
  input  wire logic                   reg_rd,
  output logic [7:0]                  reg_rdata,
  output logic                        trace_done
);
  localparam int LW = $clog2(DEPTH+1);
  dtf_pkg::dtf_ctrl_t  ctrl_q, ctrl_d;
  dtf_pkg::dtf_state_t state_q, state_d;
  logic [1:0]          blank_q, blank_d;
  logic [LW-1:0]       lead_q, lead_d;
  logic [15:0]         port_w;
  logic [15:0]         last_op_q, last_op_d;
  logic [7:0]          rdata_q, rdata_d;
  logic                tag_q, tag_d;
  logic                trig, cof_v, low_rd;
  logic [15:0]         cof_addr;
  logic                push, in_ready, pop, out_valid;
  logic [15:0]         push_data, out_data;
  logic [LW-1:0]       level;

  // ---------------------------------------------------------------
  // tag tracking and change-of-flow classification
  // ---------------------------------------------------------------
  assign trig   = cpu.exec_valid & tag_q;               // RULE15
  assign low_rd = reg_rd & (reg_addr == `DTF_REG_FIFOL);

  always_comb begin
    tag_d = tag_q;
    if (trig || cpu.flush)
      tag_d = 1'b0;                                     // RULE15
    if (cpu.fetch_valid && cpu.fetch_tag)
      tag_d = 1'b1;
    last_op_d = cpu.fetch_valid ? cpu.fetch_addr : last_op_q;
    cof_v    = 1'b0;
    cof_addr = cpu.dest_addr;
    if (cpu.exec_valid) begin
      case (cpu.cof_kind)
        dtf_pkg::COF_COND_TAKEN: begin
          cof_v    = 1'b1;
          cof_addr = cpu.exec_addr;                     // RULE11
        end
        dtf_pkg::COF_JUMP_INSN_IND,
        dtf_pkg::COF_JUMP_SUBROUTINE_INSN_IND:
          cof_v = 1'b1;                                 // RULE13
        dtf_pkg::COF_INTERRUPT,
        dtf_pkg::COF_RETURN_FROM_INTERRUPT_INSN,
        dtf_pkg::COF_RETURN_SUB:
          cof_v = 1'b1;                                 // RULE14
        default:
          cof_v = 1'b0;                                 // RULE10 RULE12
      endcase
    end
  end

  // ---------------------------------------------------------------
  // push and pop selection
  // ---------------------------------------------------------------
  always_comb begin
    push      = 1'b0;
    push_data = last_op_q;
    pop       = 1'b0;
    if (!ctrl_q.arm) begin
      push = low_rd;                                    // RULE7
      pop  = low_rd & (level == LW'(DEPTH));            // RULE8
    end else begin
      pop = low_rd & out_valid & (lead_q == '0);        // RULE3
      if (ctrl_q.evt_only) begin
        push      = trig && (state_q != dtf_pkg::ST_DONE);
        push_data = {`DTF_ZERO_BYTE, evt_data};         // RULE4
      end else begin
        push      = cof_v && (state_q == dtf_pkg::ST_RUN); // RULE5
        push_data = cof_addr;
      end
    end
  end

  // ---------------------------------------------------------------
  // sequencer, control register and read port
  // ---------------------------------------------------------------
  always_comb begin
    ctrl_d  = ctrl_q;
    state_d = state_q;
    blank_d = blank_q;
    lead_d  = lead_q;
    // data port shows the head when armed only once no blank slot stands ahead of it, when not armed only once the fifo is full
    port_w  = (out_valid && (ctrl_q.arm ? (lead_q == '0)
                                        : (level == LW'(DEPTH))))
              ? out_data : `DTF_ZERO_WORD;              // RULE3
    rdata_d = `DTF_ZERO_BYTE;
    if (reg_wr && reg_addr == `DTF_REG_CTRL)
      ctrl_d = dtf_pkg::dtf_ctrl_t'(reg_wdata[2:0]);
    case (state_q)
      dtf_pkg::ST_IDLE:
        if (ctrl_q.arm)
          state_d = (ctrl_q.end_trace || ctrl_q.evt_only)
                    ? dtf_pkg::ST_RUN : dtf_pkg::ST_WAIT;
      dtf_pkg::ST_WAIT:
        if (trig) begin
          state_d = dtf_pkg::ST_BLANK;                  // RULE5
          blank_d = `DTF_BLANK_CYC;
        end
      dtf_pkg::ST_BLANK: begin
        blank_d = blank_q - 1'b1;
        if (blank_q == 2'h1)
          state_d = dtf_pkg::ST_RUN;
      end
      dtf_pkg::ST_RUN:
        if (!in_ready)
          state_d = dtf_pkg::ST_DONE;
        else if (trig && ctrl_q.end_trace && !ctrl_q.evt_only)
          state_d = dtf_pkg::ST_DONE;                   // RULE6
      dtf_pkg::ST_DONE:
        state_d = dtf_pkg::ST_DONE;
      default:
        state_d = dtf_pkg::ST_IDLE;
    endcase
    if (!ctrl_q.arm)
      state_d = dtf_pkg::ST_IDLE;
    // blank slots ahead of the oldest entry, used up by captures and reads
    if (push && in_ready && lead_d != '0)
      lead_d = lead_d - 1'b1;
    if (ctrl_q.arm && low_rd && lead_q != '0 && lead_d != '0)
      lead_d = lead_d - 1'b1;
    if (state_q == dtf_pkg::ST_IDLE)
      lead_d = LW'(DEPTH - 1);
    if (reg_rd) begin
      case (reg_addr)
        `DTF_REG_CTRL:  rdata_d = {5'h00, ctrl_q};
        `DTF_REG_FIFOH: rdata_d = (ctrl_q.arm && ctrl_q.evt_only)
                                  ? `DTF_ZERO_BYTE
                                  : port_w[15:8];       // RULE4
        `DTF_REG_FIFOL: rdata_d = port_w[7:0];
        `DTF_REG_COUNT: rdata_d = 8'(level);            // RULE16
        default:        rdata_d = `DTF_ZERO_BYTE;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      ctrl_q    <= dtf_pkg::dtf_ctrl_t'(`DTF_CTRL_RST);
      state_q   <= dtf_pkg::ST_IDLE;
      blank_q   <= 2'h0;
      lead_q    <= LW'(DEPTH - 1);
      last_op_q <= `DTF_ZERO_WORD;
      rdata_q   <= `DTF_ZERO_BYTE;
      tag_q     <= 1'b0;
    end else begin
      ctrl_q    <= ctrl_d;
      state_q   <= state_d;
      blank_q   <= blank_d;
      lead_q    <= lead_d;
      last_op_q <= last_op_d;
      rdata_q   <= rdata_d;
      tag_q     <= tag_d;
    end
  end

  assign reg_rdata  = rdata_q;
  assign trace_done = (state_q == dtf_pkg::ST_DONE);

  // eight-entry capture buffer; filling it during a run ends the trace (ST_DONE)
  dtf_fifo #(
    .W (`DTF_ADDR_W),
    .D (DEPTH)
  ) u_fifo (
    .mclk      (mclk),
    .nrst      (nrst),
    .in_valid  (push),
    .in_ready  (in_ready),
    .in_data   (push_data),
    .out_valid (out_valid),
    .out_ready (pop),
    .out_data  (out_data),
    .level     (level)
  );

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  trig_blank_gap_a: assert property ( // RULE5
    state_q == dtf_pkg::ST_WAIT && trig
    |-> !push ##1 !push ##1 !push)
    else $error("capture inside trigger blanking");
  end_final_a: assert property ( // RULE6
    state_q == dtf_pkg::ST_RUN && ctrl_q.end_trace &&
    !ctrl_q.evt_only && trig && cof_v && in_ready
    |-> push ##1 state_q == dtf_pkg::ST_DONE)
    else $error("end trigger not stored last");
  low_read_adv_a: assert property ( // RULE3
    ctrl_q.arm && low_rd && out_valid && lead_q == '0
    |=> level == $past(level) - LW'(1) + LW'($past(push)))
    else $error("low read did not advance");
  profile_push_a: assert property ( // RULE7
    !ctrl_q.arm && low_rd && in_ready
    |-> push && push_data == last_op_q)
    else $error("profile sample not pushed");
  profile_fill_a: assert property ( // RULE8
    !ctrl_q.arm && low_rd && level != LW'(DEPTH) |-> !pop)
    else $error("profile popped before full");
  evt_high_zero_a: assert property ( // RULE4
    ctrl_q.arm && ctrl_q.evt_only && push
    |-> push_data[15:8] == `DTF_ZERO_BYTE)
    else $error("event entry high byte used");
  cof_only_a: assert property ( // RULE10
    ctrl_q.arm && !ctrl_q.evt_only && push |-> cof_v)
    else $error("sequential opcode captured");
  cond_src_a: assert property ( // RULE11
    push && ctrl_q.arm && !ctrl_q.evt_only &&
    cpu.cof_kind == dtf_pkg::COF_COND_TAKEN
    |-> push_data == cpu.exec_addr)
    else $error("branch source address wrong");
  bra_brn_none_a: assert property ( // RULE12
    cpu.exec_valid && ctrl_q.arm && !ctrl_q.evt_only &&
    (cpu.cof_kind == dtf_pkg::COF_BRANCH_ALWAYS_INSN ||
     cpu.cof_kind == dtf_pkg::COF_BRANCH_NEVER_INSN) |-> !push)
    else $error("unconditional branch captured");
  dest_store_a: assert property ( // RULE13
    push && ctrl_q.arm && !ctrl_q.evt_only &&
    cpu.cof_kind != dtf_pkg::COF_COND_TAKEN
    |-> push_data == cpu.dest_addr)
    else $error("destination address wrong");
  tag_flush_a: assert property ( // RULE15
    cpu.flush && !(cpu.fetch_valid && cpu.fetch_tag)
    |=> !trig)
    else $error("flushed tag acted");
  count_sat_a: assert property ( // RULE16
    level == LW'(DEPTH) && push |=> level == LW'(DEPTH))
    else $error("count passed depth");

  run_fill_c: cover property (
    state_q == dtf_pkg::ST_RUN ##1 state_q == dtf_pkg::ST_DONE);
  end_trig_c: cover property (
    state_q == dtf_pkg::ST_RUN && ctrl_q.end_trace && trig && push);
  profile_c:  cover property (!ctrl_q.arm && low_rd && pop);
endmodule : dtf_trace

/* verification/dtf_host_model.sv */
`timescale 1ns/100ps
// ---------------------------------------------------------------
// host debugger on the register port
// ---------------------------------------------------------------
module dtf_host_model (
  input  wire logic       mclk,
  output logic [1:0]      reg_addr,
  output logic [7:0]      reg_wdata,
  output logic            reg_wr,
  output logic            reg_rd,
  input  wire logic [7:0] reg_rdata
);
  // idle bus at time zero
  initial begin
    reg_addr  = 2'h0;
    reg_wdata = 8'hA5;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
  end

  // one-cycle write, data line scrambled once released
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge mclk);
    reg_wr    <= 1'b0;
    reg_wdata <= ~d;
  endtask : wr

  // one-cycle read, data taken in the following cycle only
  task automatic rd(input logic [1:0] a, output logic [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge mclk);
    reg_rd   <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd

  // coherent word: high byte first, the low read advances
  task automatic get_word(output logic [15:0] w);
    logic [7:0] h;
    logic [7:0] l;
    rd(2'h1, h);
    rd(2'h2, l);
    w = {h, l};
  endtask : get_word
endmodule : dtf_host_model

/* verification/dtf_trace_tb.sv */
`timescale 1ns/100ps
module dtf_trace_tb;
  logic              mclk = 1'b0;
  logic              nrst = 1'b0;
  dtf_pkg::dtf_cpu_t cpu = '0;
  logic [7:0]        evt_data = 8'h00;
  logic [1:0]        reg_addr;
  logic [7:0]        reg_wdata;
  logic              reg_wr;
  logic              reg_rd;
  logic [7:0]        reg_rdata;
  logic              trace_done;
  int                n_errors = 0;
  int                n_compared = 0;
  logic [7:0]        b;
  logic [15:0]       w;
  logic [15:0]       exp_q[$];

  always #5 mclk = ~mclk;

  dtf_trace i_dut (.mclk(mclk), .nrst(nrst), .cpu(cpu),
    .evt_data(evt_data), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .trace_done(trace_done));
  dtf_host_model i_host (.mclk(mclk), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata));

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic check(input string nm, input logic [15:0] s, e);
    n_compared++;
    if (s !== e) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", nm, e, s);
    end
  endtask : check

  task automatic give_verdict;
    $display("errors %0d compared %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : give_verdict

  // one cpu cycle
  task automatic drive(input dtf_pkg::dtf_cpu_t v);
    @(posedge mclk);
    cpu <= v;
  endtask : drive

  function automatic dtf_pkg::dtf_cpu_t fv(input logic t,
      input logic [15:0] a);
    fv = '0;
    fv.fetch_valid = 1'b1;
    fv.fetch_tag = t;
    fv.fetch_addr = a;
  endfunction : fv

  function automatic dtf_pkg::dtf_cpu_t xv(input dtf_pkg::dtf_cof_t k,
      input logic [15:0] a, d);
    xv = '0;
    xv.exec_valid = 1'b1;
    xv.cof_kind = k;
    xv.exec_addr = a;
    xv.dest_addr = d;
  endfunction : xv

  task automatic do_reset(input int n);
    @(posedge mclk);
    nrst <= 1'b0;
    cpu  <= '0;
    repeat (n) @(posedge mclk);
    nrst <= 1'b1;
  endtask : do_reset

  // count, dummy reads, then every queued word
  task automatic drain;
    i_host.rd(2'h3, b);
    check("count", {8'h00, b}, 16'(exp_q.size()));
    for (int i = 0; i < (8 - exp_q.size()) - 1; i++) begin
      i_host.rd(2'h2, b);
    end
    foreach (exp_q[i]) begin
      i_host.get_word(w);
      check("word", w, exp_q[i]);
    end
  endtask : drain

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic sc_profile;
    logic [15:0] e;
    for (int i = 0; i < 10; i++) begin
      drive(fv(1'b0, 16'hA050 + 16'(i) * 16'h0101));
      drive('0);
      drive('0);
      if (i == 9) begin
        i_host.rd(2'h1, b);
        check("prof hi", {8'h00, b}, 16'h00A1);
      end
      i_host.rd(2'h2, b);
      e = (i < 8) ? 16'h0000 : 16'h0048 + 16'(i);
      check("prof lo", {8'h00, b}, e);
    end
    i_host.wr(2'h3, 8'hFF);
    i_host.rd(2'h3, b);
    check("sat count", {8'h00, b}, 16'h0008);
    i_host.get_word(w);
    check("prof word", w, 16'hA252);
  endtask : sc_profile

  task automatic sc_start_trace;
    dtf_pkg::dtf_cof_t k;
    dtf_pkg::dtf_cpu_t fl;
    i_host.wr(2'h0, 8'h01);
    drive(fv(1'b1, 16'h0100));
    fl = '0;
    fl.flush = 1'b1;
    drive(fl);
    drive(xv(dtf_pkg::COF_SEQ, 16'h0100, 16'h0000));
    repeat (3) drive('0);
    drive(xv(dtf_pkg::COF_COND_TAKEN, 16'h0E0E, 16'h0000));
    drive(fv(1'b1, 16'h0200));
    drive(xv(dtf_pkg::COF_COND_TAKEN, 16'h0200, 16'h0000));
    drive(xv(dtf_pkg::COF_INTERRUPT, 16'h0202, 16'h0F00));
    drive(xv(dtf_pkg::COF_RETURN_SUB, 16'h0204, 16'h0F02));
    exp_q.delete();
    for (int i = 0; i < 10; i++) begin
      k = dtf_pkg::dtf_cof_t'(i);
      drive(xv(k, 16'h1000 + 16'(i), 16'h2A00 + 16'(i)));
      if (k == dtf_pkg::COF_COND_TAKEN)
        exp_q.push_back(16'h1000 + 16'(i));
      else if (k inside {dtf_pkg::COF_JUMP_INSN_IND,
          dtf_pkg::COF_JUMP_SUBROUTINE_INSN_IND, dtf_pkg::COF_INTERRUPT,
          dtf_pkg::COF_RETURN_FROM_INTERRUPT_INSN, dtf_pkg::COF_RETURN_SUB})
        exp_q.push_back(16'h2A00 + 16'(i));
    end
    drive('0);
    drain();
  endtask : sc_start_trace

  task automatic sc_end_trace;
    i_host.wr(2'h0, 8'h03);
    drive(xv(dtf_pkg::COF_COND_TAKEN, 16'h4321, 16'h0000));
    drive(fv(1'b1, 16'h4400));
    drive(xv(dtf_pkg::COF_RETURN_SUB, 16'h4400, 16'h8ACE));
    drive(xv(dtf_pkg::COF_COND_TAKEN, 16'h5555, 16'h0000));
    drive('0);
    check("done", {15'h0000, trace_done}, 16'h0001);
    exp_q = '{16'h4321, 16'h8ACE};
    drain();
  endtask : sc_end_trace

  task automatic sc_event_only;
    logic [7:0] dv[2] = '{8'hA5, 8'h3C};
    i_host.wr(2'h0, 8'h05);
    foreach (dv[i]) begin
      drive(fv(1'b1, 16'h6000));
      evt_data <= dv[i];
      drive(xv(dtf_pkg::COF_SEQ, 16'h6000, 16'h7777));
    end
    drive('0);
    exp_q = '{16'h00A5, 16'h003C};
    drain();
  endtask : sc_event_only

  // ---------------------------------------------------------------
  // main sequence and watchdog
  // ---------------------------------------------------------------
  initial begin
    do_reset(20);
    check("rdata rst", {8'h00, reg_rdata}, 16'h0000);
    check("done rst", {15'h0000, trace_done}, 16'h0000);
    i_host.rd(2'h0, b);
    check("ctrl rst", {8'h00, b}, 16'h0000);
    sc_profile();
    do_reset(3);
    sc_start_trace();
    do_reset(3);
    sc_end_trace();
    do_reset(3);
    sc_event_only();
    give_verdict();
  end

  initial begin
    repeat (100000) @(posedge mclk);
    n_errors++;
    give_verdict();
  end
endmodule : dtf_trace_tb
